/* File: irq_vec_pkg.sv */
package irq_vec_pkg;

	// bus register byte offsets
	localparam logic [7:0] OFS_MASK    = 8'h00;
	localparam logic [7:0] OFS_FLAGS   = 8'h04;
	localparam logic [7:0] OFS_BANKCTL = 8'h08;
	localparam logic [7:0] OFS_SRCSEL  = 8'h0C;
	localparam logic [7:0] OFS_VECTOR  = 8'h10;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h18;

	// flag/mask bit positions; BIT_IPI_REQ is the request field bit in bank control
	localparam int BIT_PIN0 = 0;
	localparam int BIT_PIN1 = 1;
	localparam int BIT_TIMER = 3;
	localparam int BIT_SP0_RX = 4;
	localparam int BIT_SP0_TX = 5;
	localparam int BIT_SP2_RX_DMA0 = 6;
	localparam int BIT_SP2_TX_DMA1 = 7;
	localparam int BIT_HOST = 9;
	localparam int BIT_SP1_RX_DMA2 = 10;
	localparam int BIT_SP1_TX_DMA3 = 11;
	localparam int BIT_DMA4 = 12;
	localparam int BIT_DMA5 = 13;
	localparam int BIT_IPI = 14;
	localparam int BIT_IPI_REQ = 0;

	// reserved bits 15, 8 and 2 are never implemented
	localparam logic [15:0] FLAG_IMPL  = 16'h7EFB;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	localparam logic [3:0]  SEL_RESET  = 4'h0;

	// vector locations, relative to the vector base
	localparam logic [6:0] VEC_RESET = 7'h00;
	localparam logic [6:0] VEC_NMI   = 7'h04;
	localparam logic [6:0] VEC_SW_LO = 7'h08;
	localparam logic [6:0] VEC_SW_HI = 7'h3C;
	localparam logic [6:0] VEC_PIN0  = 7'h40;
	localparam logic [6:0] VEC_RSV_A = 7'h48;
	localparam logic [6:0] VEC_RSV_B = 7'h60;
	localparam logic [6:0] VEC_LAST  = 7'h78;
	localparam logic [6:0] VEC_STEP  = 7'h04;

	typedef struct packed {
		logic       pin0;
		logic       pin1;
		logic       timer;
		logic       sp0_rx;
		logic       sp0_tx;
		logic       sp1_rx;
		logic       sp1_tx;
		logic       sp2_rx;
		logic       sp2_tx;
		logic       host;
		logic [5:0] dma;
	} irq_src_t;

	typedef struct packed {
		logic       valid;
		logic [6:0] vector;
		logic [4:0] priority_num;
		logic [3:0] bit_num;
	} vec_req_t;

endpackage : irq_vec_pkg

/* File: irq_vectoring.sv */
`timescale 1ns/1ps
// Summary of operation
// - vectors sit four words apart from 0 to 120; 124..127 unused.
// - reset vectors to 00 priority 1, nmi to 04 priority 2, software 08..3C.
// - pin0 to 40 priority 3, pin1 to 44 priority 4; 48 and 60 reserved.
// - timer 4C, port0 receive 50, port0 transmit 54.
// - 58 serves port2 receive or dma0; 5C port2 transmit or dma1.
// - host port interrupt vectors to 64, priority 12.
// - 68 serves port1 receive or dma2; 6C port1 transmit or dma3.
// - own table per subsystem; dma4 70, dma5 74, interprocessor 78.
// - partner request latched in flag bit 14, serviced when mask allows.
// - writing 1 to request field raises interrupt on the partner.
// - a new request needs the field cleared to 0 first.
// - mask and flags share one 16-bit bit layout.
// - flag 1 means pending; mask 1 means enabled.
// - host interrupt sets flag bit 9, gated by mask bit 9.
// - bits 15, 8 and 2 are reserved and inert.
// - shared bits carry either a serial port or a dma event.
module irq_vectoring (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 nmi_req,
	input  wire logic                 soft_reset_req,
	input  wire irq_vec_pkg::irq_src_t src,
	input  wire logic                 partner_ipi,
	output logic                      ipi_to_partner,
	output irq_vec_pkg::vec_req_t     core_req,
	input  wire logic                 core_ack,
	output logic                      irq,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);

	logic [15:0] interrupt_enable_mask_q;
	logic [15:0] interrupt_pending_flags_q;
	logic        interprocessor_request_field_q;
	logic [3:0]  src_sel_q;
	logic [2:0]  irq_st_q;
	logic [2:0]  irq_en_q;
	logic        partner_ipi_q;
	logic        nmi_q;
	logic        nmi_pend_q;
	logic        rst_pend_q;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] enabled;
	irq_vec_pkg::vec_req_t core_req_d;

	// AXI write channel capture
	logic        aw_held_q;
	logic        w_held_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_fire;
	logic        rd_fire;

	function automatic logic [6:0] bit_vector(input logic [3:0] b);
		logic [6:0] v;
		v = irq_vec_pkg::VEC_PIN0;
		case (b)
			4'h0: v = irq_vec_pkg::VEC_PIN0;
			4'h1: v = 7'(irq_vec_pkg::VEC_PIN0 + irq_vec_pkg::VEC_STEP);
			4'h3: v = 7'h4C;
			4'h4: v = 7'h50;
			4'h5: v = 7'h54;
			4'h6: v = 7'h58;
			4'h7: v = 7'h5C;
			4'h9: v = 7'h64;
			4'hA: v = 7'h68;
			4'hB: v = 7'h6C;
			4'hC: v = 7'h70;
			4'hD: v = 7'h74;
			4'hE: v = irq_vec_pkg::VEC_LAST;
			default: v = irq_vec_pkg::VEC_RSV_A;
		endcase
		return v;
	endfunction : bit_vector

	// priority equals vector slot index minus 13 (slot 16 is priority 3)
	function automatic logic [4:0] vec_priority(input logic [6:0] v);
		return 5'(v[6:2] - 5'h0D);
	endfunction : vec_priority

	// serial port / dma source selection for shared flag bits
	always_comb begin
		set_vec = 16'h0000;
		set_vec[irq_vec_pkg::BIT_PIN0]   = src.pin0;
		set_vec[irq_vec_pkg::BIT_PIN1]   = src.pin1;
		set_vec[irq_vec_pkg::BIT_TIMER]  = src.timer;
		set_vec[irq_vec_pkg::BIT_SP0_RX] = src.sp0_rx;
		set_vec[irq_vec_pkg::BIT_SP0_TX] = src.sp0_tx;
		set_vec[irq_vec_pkg::BIT_SP2_RX_DMA0] = src_sel_q[0] ? src.dma[0] : src.sp2_rx;
		set_vec[irq_vec_pkg::BIT_SP2_TX_DMA1] = src_sel_q[1] ? src.dma[1] : src.sp2_tx;
		set_vec[irq_vec_pkg::BIT_SP1_RX_DMA2] = src_sel_q[2] ? src.dma[2] : src.sp1_rx;
		set_vec[irq_vec_pkg::BIT_SP1_TX_DMA3] = src_sel_q[3] ? src.dma[3] : src.sp1_tx;
		set_vec[irq_vec_pkg::BIT_HOST] = src.host;
		set_vec[irq_vec_pkg::BIT_DMA4] = src.dma[4];
		set_vec[irq_vec_pkg::BIT_DMA5] = src.dma[5];
		// rising edge of partner request only
		set_vec[irq_vec_pkg::BIT_IPI] = partner_ipi & ~partner_ipi_q;
		set_vec = set_vec & irq_vec_pkg::FLAG_IMPL;
	end

	assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;

	// software clears a flag by writing 1; core acknowledge clears the taken bit
	always_comb begin
		clr_vec = 16'h0000;
		if (wr_fire && awaddr_q == irq_vec_pkg::OFS_FLAGS) begin
			clr_vec = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
		end
		if (core_ack && core_req.valid && core_req.priority_num > 5'h02) begin
			clr_vec[core_req.bit_num] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			partner_ipi_q <= 1'b0;
			nmi_q         <= 1'b0;
		end else begin
			partner_ipi_q <= partner_ipi;
			nmi_q         <= nmi_req;
		end
	end

	// set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			interrupt_pending_flags_q <= irq_vec_pkg::FLAG_RESET;
		end else begin
			interrupt_pending_flags_q <= ((interrupt_pending_flags_q & ~clr_vec) | set_vec)
				& irq_vec_pkg::FLAG_IMPL;
		end
	end

	// nmi edge and soft reset held until the core takes them
	always_ff @(posedge clk) begin
		if (srst) begin
			nmi_pend_q <= 1'b0;
			rst_pend_q <= 1'b0;
		end else begin
			if (nmi_req && !nmi_q) begin
				nmi_pend_q <= 1'b1;
			end else if (core_ack && core_req.valid
				&& core_req.vector == irq_vec_pkg::VEC_NMI) begin
				nmi_pend_q <= 1'b0;
			end
			if (soft_reset_req) begin
				rst_pend_q <= 1'b1;
			// an idle request also reads as vector 00, so valid must qualify the ack
			end else if (core_ack && core_req.valid
				&& core_req.vector == irq_vec_pkg::VEC_RESET) begin
				rst_pend_q <= 1'b0;
			end
		end
	end

	assign enabled = interrupt_pending_flags_q & interrupt_enable_mask_q;

	// lowest bit number has the smallest priority number
	always_comb begin
		core_req_d = '0;
		for (int i = 15; i >= 0; i--) begin
			if (enabled[i]) begin
				core_req_d.valid        = 1'b1;
				core_req_d.bit_num      = 4'(i);
				core_req_d.vector       = bit_vector(4'(i));
				core_req_d.priority_num = vec_priority(bit_vector(4'(i)));
			end
		end
		if (nmi_pend_q) begin
			core_req_d.valid        = 1'b1;
			core_req_d.bit_num      = 4'h0;
			core_req_d.vector       = irq_vec_pkg::VEC_NMI;
			core_req_d.priority_num = 5'h02;
		end
		if (rst_pend_q) begin
			core_req_d.valid        = 1'b1;
			core_req_d.bit_num      = 4'h0;
			core_req_d.vector       = irq_vec_pkg::VEC_RESET;
			core_req_d.priority_num = 5'h01;
		end
	end

	// registered request; drops for one cycle after an acknowledge
	always_ff @(posedge clk) begin
		if (srst) begin
			core_req <= '0;
		end else if (core_ack) begin
			core_req <= '0;
		end else begin
			core_req <= core_req_d;
		end
	end

	// request field: its level reaches the partner one cycle later; a new request needs a 0 -> 1 change
	always_ff @(posedge clk) begin
		if (srst) begin
			interprocessor_request_field_q <= 1'b0;
			ipi_to_partner                 <= 1'b0;
		end else begin
			if (wr_fire && awaddr_q == irq_vec_pkg::OFS_BANKCTL && wstrb_q[0]) begin
				interprocessor_request_field_q <= wdata_q[irq_vec_pkg::BIT_IPI_REQ];
			end
			ipi_to_partner <= interprocessor_request_field_q;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			interrupt_enable_mask_q <= irq_vec_pkg::MASK_RESET;
			src_sel_q               <= irq_vec_pkg::SEL_RESET;
			irq_en_q                <= 3'h0;
		end else if (wr_fire) begin
			case (awaddr_q)
				irq_vec_pkg::OFS_MASK: begin
					if (wstrb_q[0]) interrupt_enable_mask_q[7:0] <= wdata_q[7:0] & irq_vec_pkg::FLAG_IMPL[7:0];
					if (wstrb_q[1]) interrupt_enable_mask_q[15:8] <= wdata_q[15:8] & irq_vec_pkg::FLAG_IMPL[15:8];
				end
				irq_vec_pkg::OFS_SRCSEL: begin
					if (wstrb_q[0]) src_sel_q <= wdata_q[3:0];
				end
				irq_vec_pkg::OFS_IRQ_EN: begin
					if (wstrb_q[0]) irq_en_q <= wdata_q[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// summary events: [0] pending flag raised, [1] nmi, [2] partner request; read clears
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_st_q <= 3'h0;
		end else begin
			if (rd_fire && s_axi_araddr == irq_vec_pkg::OFS_IRQ_ST) begin
				irq_st_q <= 3'h0;
			end
			if (|set_vec) irq_st_q[0] <= 1'b1;
			if (nmi_req && !nmi_q) irq_st_q[1] <= 1'b1;
			if (set_vec[irq_vec_pkg::BIT_IPI]) irq_st_q[2] <= 1'b1;
		end
	end

	assign irq = |(irq_st_q & irq_en_q);

	// write address/data accepted in either order, response after both
	assign s_axi_awready = ~aw_held_q;
	assign s_axi_wready  = ~w_held_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_held_q) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && !w_held_q) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q > irq_vec_pkg::OFS_IRQ_EN) ? 2'h2 : 2'h0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
			end
		end
	end

	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case ({s_axi_araddr[7:2], 2'h0})
				irq_vec_pkg::OFS_MASK:    s_axi_rdata <= {16'h0000, interrupt_enable_mask_q};
				irq_vec_pkg::OFS_FLAGS:   s_axi_rdata <= {16'h0000, interrupt_pending_flags_q};
				irq_vec_pkg::OFS_BANKCTL: s_axi_rdata <= {31'h0, interprocessor_request_field_q};
				irq_vec_pkg::OFS_SRCSEL:  s_axi_rdata <= {28'h0, src_sel_q};
				irq_vec_pkg::OFS_VECTOR:  s_axi_rdata <= {19'h0, core_req.valid, core_req.priority_num, core_req.vector};
				irq_vec_pkg::OFS_IRQ_ST:  s_axi_rdata <= {29'h0, irq_st_q};
				irq_vec_pkg::OFS_IRQ_EN:  s_axi_rdata <= {29'h0, irq_en_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	a_ipi_latch: assert property (@(posedge clk) disable iff (srst)
		partner_ipi && !partner_ipi_q |=> interrupt_pending_flags_q[14])
		else $error("partner request not latched in flag 14");

	a_rsv_bits: assert property (@(posedge clk) disable iff (srst)
		(interrupt_pending_flags_q & ~irq_vec_pkg::FLAG_IMPL) == 16'h0000)
		else $error("reserved flag bit set");

	a_ipi_edge: assert property (@(posedge clk) disable iff (srst)
		$rose(interprocessor_request_field_q) |=> ipi_to_partner)
		else $error("request field did not raise partner interrupt");

	a_host_flag: assert property (@(posedge clk) disable iff (srst)
		src.host |=> interrupt_pending_flags_q[9])
		else $error("host interrupt not pending");

	a_reset_vec: assert property (@(posedge clk) disable iff (srst)
		rst_pend_q && !core_ack |=> core_req.vector == 7'h00 && core_req.priority_num == 5'h01)
		else $error("reset not at vector 00");

	a_nmi_vec: assert property (@(posedge clk) disable iff (srst)
		nmi_pend_q && !rst_pend_q && !core_ack |=> core_req.vector == 7'h04)
		else $error("nmi not taken ahead of maskable");

	a_masked_quiet: assert property (@(posedge clk) disable iff (srst)
		core_req.valid && core_req.priority_num > 5'h02
		|-> |($past(interrupt_enable_mask_q) & (16'h0001 << core_req.bit_num)))
		else $error("masked source requested");

	// acknowledge withdraws the request so the core cannot take it twice
	a_ack_drop: assert property (@(posedge clk) disable iff (srst)
		core_ack |=> !core_req.valid)
		else $error("request not withdrawn after acknowledge");

	a_ipi_raise: assert property (@(posedge clk) disable iff (srst)
		!ipi_to_partner && interprocessor_request_field_q |=> ipi_to_partner)
		else $error("partner request not raised");

	a_vec_range: assert property (@(posedge clk) disable iff (srst)
		core_req.valid |-> core_req.vector <= 7'h78 && core_req.vector[1:0] == 2'h0
		&& core_req.vector != 7'h48 && core_req.vector != 7'h60)
		else $error("vector outside table");

	a_timer_prio: assert property (@(posedge clk) disable iff (srst)
		core_req.valid && core_req.bit_num == 4'h3 && core_req.priority_num > 5'h02
		|-> core_req.vector == 7'h4C && core_req.priority_num == 5'h06)
		else $error("timer vector wrong");

endmodule : irq_vectoring

/* File: periph_partner_model.sv */
`timescale 1ns/1ps
module periph_partner_model (
	input  wire logic             clk,
	input  wire logic             ipi_to_partner,
	output irq_vec_pkg::irq_src_t src,
	output logic                  partner_ipi
);
	int   ipi_seen;
	logic ipi_d;

	initial begin
		src = '0;
		partner_ipi = 1'b0;
		ipi_seen = 0;
		ipi_d = 1'b0;
	end

	// the far core reacts to a rising level only, so a held request counts once
	always @(posedge clk) begin
		ipi_d <= ipi_to_partner;
		if (ipi_to_partner === 1'b1 && ipi_d === 1'b0)
			ipi_seen <= ipi_seen + 1;
	end

	// one-cycle event on the source behind flag bit b; dma picks the channel of a shared bit
	task automatic fire(input int b, input logic dma);
		irq_vec_pkg::irq_src_t v;
		v = '0;
		case (b)
			0: v.pin0 = 1'b1;
			1: v.pin1 = 1'b1;
			3: v.timer = 1'b1;
			4: v.sp0_rx = 1'b1;
			5: v.sp0_tx = 1'b1;
			6: if (dma) v.dma[0] = 1'b1; else v.sp2_rx = 1'b1;
			7: if (dma) v.dma[1] = 1'b1; else v.sp2_tx = 1'b1;
			9: v.host = 1'b1;
			10: if (dma) v.dma[2] = 1'b1; else v.sp1_rx = 1'b1;
			11: if (dma) v.dma[3] = 1'b1; else v.sp1_tx = 1'b1;
			12: v.dma[4] = 1'b1;
			13: v.dma[5] = 1'b1;
			default: partner_ipi <= 1'b1;
		endcase
		src <= v;
		@(posedge clk);
		src <= '0;
		partner_ipi <= 1'b0;
	endtask : fire
endmodule : periph_partner_model

/* File: test_dual_core_interrupt_vectoring.sv */
`timescale 1ns/1ps
module test_dual_core_interrupt_vectoring;
	logic                  clk, srst, nmi_req, soft_reset_req, core_ack, irq, ipi_to_partner;
	logic                  partner_ipi;
	irq_vec_pkg::irq_src_t src;
	irq_vec_pkg::vec_req_t core_req;
	logic [7:0]            s_axi_awaddr, s_axi_araddr;
	logic [31:0]           s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                  s_axi_rvalid, s_axi_rready;
	int                    num_errors, n_tests, cyc;
	int                    bits[13] = '{0, 1, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14};

	irq_vectoring u_dut (.clk(clk), .srst(srst), .nmi_req(nmi_req),
		.soft_reset_req(soft_reset_req), .src(src), .partner_ipi(partner_ipi),
		.ipi_to_partner(ipi_to_partner), .core_req(core_req), .core_ack(core_ack), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	periph_partner_model u_peer (.clk(clk), .ipi_to_partner(ipi_to_partner), .src(src),
		.partner_ipi(partner_ipi));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			$display("[FAIL] %0t run hung", $time);
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// handshakes are judged at the falling edge, acted on at the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		r = 2'h3;
		forever begin
			@(negedge clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (b) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		// one idle edge so a following call never reassigns bready in this step
		@(posedge clk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge clk);
			ar = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ar)
				s_axi_arvalid <= 1'b0;
			if (rv) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		@(posedge clk);
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
	endtask : wr

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		check(d, exp, what);
		check(32'(r), 32'h0, "read response");
	endtask : chk_rd

	// settled look at core_req after n edges, then back onto a rising edge
	task automatic chk_req(input int n, input logic [31:0] exp, input int w, input string what);
		repeat (n) @(posedge clk);
		@(negedge clk);
		check(32'(core_req) >> w, exp, what);
		@(posedge clk);
	endtask : chk_req

	task automatic ack();
		core_ack <= 1'b1;
		@(posedge clk);
		core_ack <= 1'b0;
	endtask : ack

	function automatic logic [31:0] exp_req(input int b);
		return 32'({1'b1, 7'(8'h40 + 4 * b), 5'(b + 3), 4'(b)});
	endfunction : exp_req

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		check(32'({irq, core_req.valid}), 32'h0, "outputs after reset");
		chk_rd(irq_vec_pkg::OFS_MASK, 32'h0, "mask reset");
		chk_rd(irq_vec_pkg::OFS_FLAGS, 32'h0, "flags reset");
		chk_rd(irq_vec_pkg::OFS_BANKCTL, 32'h0, "bank ctl reset");
		wr(irq_vec_pkg::OFS_MASK, 32'hFFFFFFFF);
		chk_rd(irq_vec_pkg::OFS_MASK, 32'h00007EFB, "reserved mask bits");
		axi_rd(8'h1C, d, r);
		check(32'(r), 32'h2, "unmapped read");
		axi_wr(8'h1C, 32'hFFFFFFFF, r);
		check(32'(r), 32'h2, "unmapped write");
		$display("test regs done");
	endtask : t_regs

	task automatic t_sources();
		int b;
		for (int p = 0; p < 2; p++) begin
			wr(irq_vec_pkg::OFS_SRCSEL, p ? 32'h0000000F : 32'h0);
			foreach (bits[i]) begin
				b = bits[i];
				if (p == 1 && !(b inside {6, 7, 10, 11}))
					continue;
				if (b inside {6, 7, 10, 11}) begin
					u_peer.fire(b, p == 0);
					chk_rd(irq_vec_pkg::OFS_FLAGS, 32'h0, "unselected source");
				end
				u_peer.fire(b, p == 1);
				chk_req(2, exp_req(b), 0, "vector");
				chk_rd(irq_vec_pkg::OFS_FLAGS, 32'h1 << b, "flag bit");
				wr(irq_vec_pkg::OFS_FLAGS, 32'h1 << b);
				chk_rd(irq_vec_pkg::OFS_FLAGS, 32'h0, "flag clear");
			end
		end
		$display("test sources done");
	endtask : t_sources

	task automatic t_priority();
		u_peer.fire(13, 1'b0);
		@(posedge clk);
		u_peer.fire(3, 1'b0);
		chk_req(2, exp_req(3), 0, "timer first");
		ack();
		chk_req(3, exp_req(13), 0, "dma5 second");
		ack();
		chk_req(3, 32'h0, 16, "all taken");
		$display("test priority done");
	endtask : t_priority

	task automatic t_mask();
		wr(irq_vec_pkg::OFS_MASK, 32'h0);
		u_peer.fire(9, 1'b0);
		chk_req(2, 32'h0, 16, "masked host");
		chk_rd(irq_vec_pkg::OFS_FLAGS, 32'h00000200, "host pending");
		wr(irq_vec_pkg::OFS_MASK, 32'h00000200);
		chk_req(2, exp_req(9), 0, "host enabled");
		chk_rd(irq_vec_pkg::OFS_VECTOR, 32'h00001664, "vector status");
		wr(irq_vec_pkg::OFS_FLAGS, 32'h0000FFFF);
		$display("test mask done");
	endtask : t_mask

	task automatic t_nmi();
		wr(irq_vec_pkg::OFS_MASK, 32'h0);
		nmi_req <= 1'b1;
		chk_req(3, 32'({1'b1, 7'h04, 5'h02}), 4, "nmi vector");
		soft_reset_req <= 1'b1;
		@(posedge clk);
		soft_reset_req <= 1'b0;
		chk_req(3, 32'({1'b1, 7'h00, 5'h01}), 4, "reset vector");
		ack();
		chk_req(3, 32'({1'b1, 7'h04, 5'h02}), 4, "nmi after reset");
		ack();
		nmi_req <= 1'b0;
		chk_req(3, 32'h0, 16, "nothing pending");
		$display("test nmi done");
	endtask : t_nmi

	task automatic t_ipi();
		wr(irq_vec_pkg::OFS_BANKCTL, 32'h1);
		chk_req(3, 32'h0, 16, "no local vector");
		check(32'(u_peer.ipi_seen), 32'h1, "request sent");
		wr(irq_vec_pkg::OFS_BANKCTL, 32'h1);
		chk_req(3, 32'h0, 16, "no local vector");
		check(32'(u_peer.ipi_seen), 32'h1, "no repeat without clear");
		wr(irq_vec_pkg::OFS_BANKCTL, 32'h0);
		wr(irq_vec_pkg::OFS_BANKCTL, 32'h1);
		chk_req(3, 32'h0, 16, "no local vector");
		check(32'(u_peer.ipi_seen), 32'h2, "request after clear");
		wr(irq_vec_pkg::OFS_BANKCTL, 32'h0);
		$display("test ipi done");
	endtask : t_ipi

	task automatic t_irq();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(irq_vec_pkg::OFS_IRQ_ST, d, r);
		wr(irq_vec_pkg::OFS_IRQ_EN, 32'h1);
		u_peer.fire(0, 1'b0);
		chk_req(2, 32'h0, 16, "pin0 masked");
		check(32'(irq), 32'h1, "irq raised");
		wr(irq_vec_pkg::OFS_FLAGS, 32'h1);
		chk_rd(irq_vec_pkg::OFS_IRQ_ST, 32'h1, "status sticky");
		check(32'(irq), 32'h0, "irq cleared");
		wr(irq_vec_pkg::OFS_IRQ_EN, 32'h0);
		u_peer.fire(0, 1'b0);
		chk_req(2, 32'h0, 16, "pin0 masked");
		check(32'(irq), 32'h0, "irq masked");
		chk_rd(irq_vec_pkg::OFS_IRQ_ST, 32'h1, "masked status");
		$display("test irq done");
	endtask : t_irq

	initial begin
		srst = 1'b1;
		nmi_req = 1'b0;
		soft_reset_req = 1'b0;
		core_ack = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		num_errors = 0;
		n_tests = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_sources();
		t_priority();
		t_mask();
		t_nmi();
		t_ipi();
		t_irq();
		report_and_stop();
	end
endmodule : test_dual_core_interrupt_vectoring
